// ===== hdl/smie_regs.svh
// constants for the shift, move and indirect load execution block
`ifndef SMIE_REGS_SVH
`define SMIE_REGS_SVH
`define SMIE_DATA_W      8
`define SMIE_PTR_W       16
`define SMIE_FADDR_W     7
`define SMIE_OFS_W       6
`define SMIE_MSB         7
`define SMIE_ACC_RST     8'h00
`define SMIE_PTR_RST     16'h0000
`define SMIE_FLAG_RST    1'b0
`define SMIE_BYTE_ZERO   8'h00
`define SMIE_PTR_ONE     16'h0001
`define SMIE_DEST_ACC    1'b0
`define SMIE_MODE_PREINC 2'h0
`define SMIE_MODE_PREDEC 2'h1
`define SMIE_MODE_POSTINC 2'h2
`define SMIE_MODE_POSTDEC 2'h3
`define SMIE_MODE_DEC_BIT  0
`define SMIE_MODE_POST_BIT 1
`define SMIE_ALIAS0_ADDR 7'h00
`define SMIE_ALIAS1_ADDR 7'h01
`endif

// ===== hdl/smie_pkg.sv
// types for the shift, move and indirect load execution block
package smie_pkg;
    typedef enum logic [1:0] {SMIE_OP_NONE, SMIE_OP_SHIFT_RIGHT, SMIE_OP_COPY_FILE,
                              SMIE_OP_INDIRECT_LOAD} smie_op_t;
    typedef enum logic [1:0] {SMIE_IDLE, SMIE_READ, SMIE_WRITE} smie_state_t;
endpackage : smie_pkg

// ===== hdl/smie_ptr_unit.sv
// one pointer register with pre/post step and relative addressing
`timescale 1ns/1ps
`default_nettype none
`include "smie_regs.svh"
module smie_ptr_unit
(
    input  wire logic                      clk,      // core clock
    input  wire logic                      rst_n,    // sync reset, active low
    input  wire logic                      ce,       // clock enable
    input  wire logic                      sel,      // this pointer is used
    input  wire logic                      rel,      // relative form
    input  wire logic [1:0]                mode,     // update_mode
    input  wire logic [`SMIE_OFS_W-1:0]    ofs,      // signed offset
    input  wire logic                      commit,   // apply step
    input  wire logic                      ld,       // direct pointer load
    input  wire logic [`SMIE_PTR_W-1:0]    ld_val,   // value to load
    output logic      [`SMIE_PTR_W-1:0]    ptr,      // pointer value
    output logic      [`SMIE_PTR_W-1:0]    eff_addr  // effective address
);
    logic [`SMIE_PTR_W-1:0] ptr_r;
    logic [`SMIE_PTR_W-1:0] ptr_nxt;
    logic [`SMIE_PTR_W-1:0] stepped;
    logic [`SMIE_PTR_W-1:0] ofs_ext;

    assign ofs_ext = {{(`SMIE_PTR_W-`SMIE_OFS_W){ofs[`SMIE_OFS_W-1]}}, ofs};

    always_comb
    begin
        // modulo 2^16 wrap on step
        if (mode[`SMIE_MODE_DEC_BIT])
            stepped = ptr_r - `SMIE_PTR_ONE;
        else
            stepped = ptr_r + `SMIE_PTR_ONE;
        if (rel)
            eff_addr = ptr_r + ofs_ext;
        else if (mode[`SMIE_MODE_POST_BIT])
            eff_addr = ptr_r;
        else
            eff_addr = stepped;
        ptr_nxt = ptr_r;
        if (ld)
            ptr_nxt = ld_val;
        else if (commit && sel && !rel)
            ptr_nxt = stepped;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ptr_r <= `SMIE_PTR_RST;
        else if (ce)
            ptr_r <= ptr_nxt;
    end

    assign ptr = ptr_r;

    property p_rel_keeps;
        @(posedge clk) disable iff (!rst_n)
        (ce && commit && sel && rel && !ld) |=> (ptr_r == $past(ptr_r));
    endproperty
    a_rel_keeps: assert property (p_rel_keeps) else $error("relative form moved pointer");

    property p_step_one;
        @(posedge clk) disable iff (!rst_n)
        (ce && commit && sel && !rel && !ld) |=>
            (ptr_r == ($past(mode[`SMIE_MODE_DEC_BIT]) ? $past(ptr_r) - `SMIE_PTR_ONE
                                                       : $past(ptr_r) + `SMIE_PTR_ONE));
    endproperty
    a_step_one: assert property (p_step_one) else $error("pointer step wrong");
endmodule : smie_ptr_unit
`default_nettype wire

// ===== hdl/smie_exec.sv
// execution unit for right shift, file copy and indirect load
`timescale 1ns/1ps
`default_nettype none
`include "smie_regs.svh"
module smie_exec
    import smie_pkg::*;
(
    input  wire logic                       clk,        // core clock, 125 MHz
    input  wire logic                       rst_n,      // sync reset, active low
    input  wire logic                       ce,         // clock enable
    input  wire logic                       start,      // issue instruction
    input  wire smie_pkg::smie_op_t         op,         // instruction
    input  wire logic [`SMIE_FADDR_W-1:0]   faddr,      // file address operand
    input  wire logic                       dest_sel,   // result_target_bit
    input  wire logic                       ptr_sel,    // pointer number
    input  wire logic                       rel,        // relative form
    input  wire logic [1:0]                 upd_mode,   // update_mode
    input  wire logic [`SMIE_OFS_W-1:0]     offset,     // signed offset
    input  wire logic                       ptr_ld,     // load pointer directly
    input  wire logic [`SMIE_PTR_W-1:0]     ptr_ld_val, // pointer load value
    output logic                            busy,       // executing
    output logic                            done,       // instruction finished
    output logic                            mem_rd,     // data memory read strobe
    output logic                            mem_wr,     // data memory write strobe
    output logic      [`SMIE_PTR_W-1:0]     mem_addr,   // data memory address
    output logic      [`SMIE_DATA_W-1:0]    mem_wdata,  // write data
    input  wire logic [`SMIE_DATA_W-1:0]    mem_rdata,  // read data, next cycle
    output logic      [`SMIE_DATA_W-1:0]    acc,        // accumulator
    output logic                            carry,      // carry flag
    output logic                            zero,       // zero flag
    output logic      [`SMIE_PTR_W-1:0]     ptr0,       // pointer 0
    output logic      [`SMIE_PTR_W-1:0]     ptr1        // pointer 1
);
    import smie_pkg::*;

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    logic [`SMIE_PTR_W-1:0] ea0;
    logic [`SMIE_PTR_W-1:0] ea1;
    logic                   commit;
    smie_op_t               op_r;
    smie_op_t               op_nxt;
    logic                   ptr_sel_r;
    logic                   ptr_sel_nxt;
    logic                   rel_r;
    logic [1:0]             mode_r;
    logic [`SMIE_OFS_W-1:0] ofs_r;

    smie_ptr_unit u_ptr0
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .sel      (!ptr_sel_r),
        .rel      (rel_r),
        .mode     (mode_r),
        .ofs      (ofs_r),
        .commit   (commit),
        .ld       (ptr_ld && !ptr_sel),
        .ld_val   (ptr_ld_val),
        .ptr      (ptr0),
        .eff_addr (ea0)
    );

    smie_ptr_unit u_ptr1
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .sel      (ptr_sel_r),
        .rel      (rel_r),
        .mode     (mode_r),
        .ofs      (ofs_r),
        .commit   (commit),
        .ld       (ptr_ld && ptr_sel),
        .ld_val   (ptr_ld_val),
        .ptr      (ptr1),
        .eff_addr (ea1)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    smie_state_t               st_r;
    smie_state_t               st_nxt;
    logic [`SMIE_FADDR_W-1:0]  faddr_r;
    logic [`SMIE_FADDR_W-1:0]  faddr_nxt;
    logic                      dest_r;
    logic                      dest_nxt;
    logic                      rel_nxt;
    logic [1:0]                mode_nxt;
    logic [`SMIE_OFS_W-1:0]    ofs_nxt;
    logic [`SMIE_DATA_W-1:0]   acc_r;
    logic [`SMIE_DATA_W-1:0]   acc_nxt;
    logic                      c_r;
    logic                      c_nxt;
    logic                      z_r;
    logic                      z_nxt;
    logic [`SMIE_DATA_W-1:0]   result;
    logic [`SMIE_PTR_W-1:0]    file_addr;
    logic [`SMIE_PTR_W-1:0]    ea_sel;
    logic                      done_nxt;
    logic                      done_r;

    assign ea_sel = ptr_sel_r ? ea1 : ea0;

    always_comb
    begin
        // alias addresses redirect to the pointer value
        if (faddr_r == `SMIE_ALIAS0_ADDR)
            file_addr = ptr0;
        else if (faddr_r == `SMIE_ALIAS1_ADDR)
            file_addr = ptr1;
        else
            file_addr = {{(`SMIE_PTR_W-`SMIE_FADDR_W){1'b0}}, faddr_r};
    end

    always_comb
    begin
        if (op_r == SMIE_OP_SHIFT_RIGHT)
            result = {1'b0, mem_rdata[`SMIE_MSB:1]};
        else
            result = mem_rdata;
    end

    always_comb
    begin
        st_nxt      = st_r;
        op_nxt      = op_r;
        faddr_nxt   = faddr_r;
        dest_nxt    = dest_r;
        ptr_sel_nxt = ptr_sel_r;
        rel_nxt     = rel_r;
        mode_nxt    = mode_r;
        ofs_nxt     = ofs_r;
        acc_nxt     = acc_r;
        c_nxt       = c_r;
        z_nxt       = z_r;
        done_nxt    = 1'b0;
        commit      = 1'b0;
        mem_rd      = 1'b0;
        mem_wr      = 1'b0;
        mem_addr    = file_addr;
        case (st_r)
            SMIE_IDLE:
            begin
                if (start && op != SMIE_OP_NONE)
                begin
                    st_nxt      = SMIE_READ;
                    op_nxt      = op;
                    faddr_nxt   = faddr;
                    dest_nxt    = dest_sel;
                    ptr_sel_nxt = ptr_sel;
                    rel_nxt     = rel;
                    mode_nxt    = upd_mode;
                    ofs_nxt     = offset;
                end
            end
            SMIE_READ:
            begin
                mem_rd = 1'b1;
                if (op_r == SMIE_OP_INDIRECT_LOAD)
                    mem_addr = ea_sel;
                st_nxt = SMIE_WRITE;
            end
            SMIE_WRITE:
            begin
                if (op_r == SMIE_OP_INDIRECT_LOAD)
                begin
                    acc_nxt = mem_rdata;
                    commit  = 1'b1;
                end
                else if (dest_r == `SMIE_DEST_ACC)
                    acc_nxt = result;
                else
                begin
                    mem_wr = 1'b1;
                end
                if (op_r == SMIE_OP_SHIFT_RIGHT)
                    c_nxt = mem_rdata[0];
                z_nxt    = (result == `SMIE_BYTE_ZERO);
                done_nxt = 1'b1;
                st_nxt   = SMIE_IDLE;
            end
            default:
                st_nxt = SMIE_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r      <= SMIE_IDLE;
            op_r      <= SMIE_OP_NONE;
            faddr_r   <= '0;
            dest_r    <= 1'b0;
            ptr_sel_r <= 1'b0;
            rel_r     <= 1'b0;
            mode_r    <= `SMIE_MODE_PREINC;
            ofs_r     <= '0;
            acc_r     <= `SMIE_ACC_RST;
            c_r       <= `SMIE_FLAG_RST;
            z_r       <= `SMIE_FLAG_RST;
            done_r    <= 1'b0;
        end
        else if (ce)
        begin
            st_r      <= st_nxt;
            op_r      <= op_nxt;
            faddr_r   <= faddr_nxt;
            dest_r    <= dest_nxt;
            ptr_sel_r <= ptr_sel_nxt;
            rel_r     <= rel_nxt;
            mode_r    <= mode_nxt;
            ofs_r     <= ofs_nxt;
            acc_r     <= acc_nxt;
            c_r       <= c_nxt;
            z_r       <= z_nxt;
            done_r    <= done_nxt;
        end
    end

    // write data is the result computed this cycle
    assign mem_wdata = result;
    assign acc       = acc_r;
    assign carry     = c_r;
    assign zero      = z_r;
    assign done      = done_r;
    assign busy      = (st_r != SMIE_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_shift_res;
        @(posedge clk) disable iff (!rst_n)
        (ce && mem_wr && op_r == SMIE_OP_SHIFT_RIGHT)
            |-> (mem_wdata == {1'b0, mem_rdata[`SMIE_MSB:1]});
    endproperty
    a_shift_res: assert property (p_shift_res) else $error("shift result wrong");

    property p_shift_carry;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE && op_r == SMIE_OP_SHIFT_RIGHT) |=> (carry == $past(mem_rdata[0]));
    endproperty
    a_shift_carry: assert property (p_shift_carry) else $error("carry not bit 0");

    property p_dest_acc;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE && op_r != SMIE_OP_INDIRECT_LOAD && !dest_r)
            |-> !mem_wr ##1 (acc == $past(result));
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

    property p_dest_file;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE && op_r != SMIE_OP_INDIRECT_LOAD && dest_r) |-> mem_wr;
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file not written");

    property p_copy_same;
        @(posedge clk) disable iff (!rst_n)
        (ce && mem_wr && op_r == SMIE_OP_COPY_FILE) |-> (mem_wdata == mem_rdata);
    endproperty
    a_copy_same: assert property (p_copy_same) else $error("copy altered data");

    property p_load_acc;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE && op_r == SMIE_OP_INDIRECT_LOAD)
            |=> (acc == $past(mem_rdata)) && (zero == (acc == `SMIE_BYTE_ZERO));
    endproperty
    a_load_acc: assert property (p_load_acc) else $error("indirect load wrong");

    property p_zero_flag;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE) |=> (zero == ($past(result) == `SMIE_BYTE_ZERO));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_issue_len;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_IDLE && start && op != SMIE_OP_NONE) ##1 ce |-> mem_rd;
    endproperty
    a_issue_len: assert property (p_issue_len) else $error("read not issued");

    property p_alias_addr;
        @(posedge clk) disable iff (!rst_n)
        (st_r == SMIE_READ && op_r != SMIE_OP_INDIRECT_LOAD && faddr_r == `SMIE_ALIAS1_ADDR)
            |-> (mem_addr == ptr1);
    endproperty
    a_alias_addr: assert property (p_alias_addr) else $error("alias miss");

    property p_pre_addr;
        @(posedge clk) disable iff (!rst_n)
        (st_r == SMIE_READ && op_r == SMIE_OP_INDIRECT_LOAD && !rel_r && !ptr_sel_r
            && !mode_r[`SMIE_MODE_POST_BIT])
            |-> (mem_addr == (mode_r[`SMIE_MODE_DEC_BIT] ? ptr0 - `SMIE_PTR_ONE
                                                         : ptr0 + `SMIE_PTR_ONE));
    endproperty
    a_pre_addr: assert property (p_pre_addr) else $error("pre address");

    property p_carry_keep;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_r == SMIE_WRITE && op_r != SMIE_OP_SHIFT_RIGHT) |=> (carry == $past(carry));
    endproperty
    a_carry_keep: assert property (p_carry_keep) else $error("carry changed");
endmodule : smie_exec
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the shift, move and indirect load execution block
`timescale 1ns/1ps
`default_nettype none
`include "smie_regs.svh"
module tb;
    import smie_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                     clk = 1'b0;
    logic                     rst_n;
    logic                     ce;
    logic                     start;
    smie_op_t                 op;
    logic [`SMIE_FADDR_W-1:0] faddr;
    logic                     dest_sel;
    logic                     ptr_sel;
    logic                     rel;
    logic [1:0]               upd_mode;
    logic [`SMIE_OFS_W-1:0]   offset;
    logic                     ptr_ld;
    logic [`SMIE_PTR_W-1:0]   ptr_ld_val;
    logic                     busy;
    logic                     done;
    logic                     mem_rd;
    logic                     mem_wr;
    logic [`SMIE_PTR_W-1:0]   mem_addr;
    logic [`SMIE_DATA_W-1:0]  mem_wdata;
    logic [`SMIE_DATA_W-1:0]  mem_rdata = 8'h00;
    logic [`SMIE_DATA_W-1:0]  acc;
    logic                     carry;
    logic                     zero;
    logic [`SMIE_PTR_W-1:0]   ptr0;
    logic [`SMIE_PTR_W-1:0]   ptr1;
    logic [`SMIE_DATA_W-1:0]  mem [0:65535];
    logic [`SMIE_DATA_W-1:0]  exp_acc;
    logic                     exp_c;
    logic [`SMIE_PTR_W-1:0]   exp_p [0:1];
    int                       err_count;
    int                       comparisons;

    smie_exec u_smie_exec (.clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .op(op),
        .faddr(faddr), .dest_sel(dest_sel), .ptr_sel(ptr_sel), .rel(rel),
        .upd_mode(upd_mode), .offset(offset), .ptr_ld(ptr_ld), .ptr_ld_val(ptr_ld_val),
        .busy(busy), .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .carry(carry),
        .zero(zero), .ptr0(ptr0), .ptr1(ptr1));

    // ----------------------------------------
    // clock, data memory and watchdog
    // ----------------------------------------
    always #4 clk = ~clk;

    // read data follows one cycle after the strobe and is held
    always @(posedge clk)
    begin
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task give_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task chk_ptrs();
        check(ptr0, exp_p[0]);
        check(ptr1, exp_p[1]);
    endtask : chk_ptrs

    task load_ptr(input logic ps, input logic [15:0] val);
        @(negedge clk);
        ptr_ld = 1'b1;
        ptr_sel = ps;
        ptr_ld_val = val;
        @(negedge clk);
        ptr_ld = 1'b0;
        exp_p[ps] = val;
        chk_ptrs();
    endtask : load_ptr

    // drive the operands of one instruction with start raised
    task issue(input smie_op_t o, input logic [6:0] fa, input logic d, input logic ps,
               input logic rl, input logic [1:0] md, input logic [5:0] ofs);
        @(negedge clk);
        start = 1'b1;
        op = o;
        faddr = fa;
        dest_sel = d;
        ptr_sel = ps;
        rel = rl;
        upd_mode = md;
        offset = ofs;
    endtask : issue

    // one instruction through its fixed three-cycle walk
    task do_op(input smie_op_t o, input logic [6:0] fa, input logic d, input logic ps,
               input logic rl, input logic [1:0] md, input logic [5:0] ofs,
               input logic [15:0] ea, input logic [7:0] res, input logic ec);
        logic wr;
        wr = d && (o != SMIE_OP_INDIRECT_LOAD);
        issue(o, fa, d, ps, rl, md, ofs);
        @(negedge clk);
        start = 1'b0;
        check({busy, done, mem_rd}, 3'h5);
        check(mem_addr, ea);
        @(negedge clk);
        check({mem_rd, mem_wr}, {1'b0, wr});
        if (wr)
            check(mem_wdata, res);
        @(negedge clk);
        check({busy, done, mem_wr}, 3'h2);
        if (!wr)
            exp_acc = res;
        exp_c = ec;
        check(acc, exp_acc);
        check(carry, exp_c);
        check(zero, res == 8'h00);
        if (wr)
            check(mem[ea], res);
    endtask : do_op

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_reset();
        check(acc, 8'h00);
        check({carry, zero, busy, done, mem_rd, mem_wr}, 6'h00);
        chk_ptrs();
    endtask : test_reset

    task test_shift();
        mem[16'h0023] = 8'h81;
        mem[16'h0024] = 8'h01;
        mem[16'h0025] = 8'hFE;
        do_op(SMIE_OP_SHIFT_RIGHT, 7'h23, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0023, 8'h40, 1'b1);
        do_op(SMIE_OP_SHIFT_RIGHT, 7'h24, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0024, 8'h00, 1'b1);
        do_op(SMIE_OP_SHIFT_RIGHT, 7'h25, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0025, 8'h7F, 1'b0);
    endtask : test_shift

    task test_copy();
        mem[16'h0030] = 8'h00;
        mem[16'h0031] = 8'hA5;
        do_op(SMIE_OP_COPY_FILE, 7'h30, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0030, 8'h00, exp_c);
        do_op(SMIE_OP_COPY_FILE, 7'h31, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0031, 8'hA5, exp_c);
    endtask : test_copy

    // every mode at the wrap boundary, pointers alternating
    task test_modes();
        logic        ps;
        logic [15:0] base;
        logic [15:0] step;
        logic [15:0] ea;
        mem[16'h0000] = 8'h00;
        mem[16'hFFFF] = 8'h7E;
        for (int m = 0; m < 4; m++)
        begin
            ps = m[0];
            base = m[0] ? 16'h0000 : 16'hFFFF;
            step = m[0] ? 16'hFFFF : 16'h0001;
            ea = m[1] ? base : base + step;
            load_ptr(ps, base);
            do_op(SMIE_OP_INDIRECT_LOAD, 7'h00, 1'b0, ps, 1'b0, m[1:0], 6'h00,
                  ea, mem[ea], exp_c);
            exp_p[ps] = base + step;
            chk_ptrs();
        end
    endtask : test_modes

    // second load asks for a file destination, which indirect load ignores
    task test_rel();
        load_ptr(1'b0, 16'h1000);
        mem[16'h0FE0] = 8'h11;
        mem[16'h101F] = 8'h00;
        do_op(SMIE_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, 1'b1, 2'h0, 6'h20,
              16'h0FE0, 8'h11, exp_c);
        chk_ptrs();
        do_op(SMIE_OP_INDIRECT_LOAD, 7'h00, 1'b1, 1'b0, 1'b1, 2'h3, 6'h1F,
              16'h101F, 8'h00, exp_c);
        chk_ptrs();
    endtask : test_rel

    task test_alias();
        load_ptr(1'b0, 16'h0234);
        load_ptr(1'b1, 16'hBEEF);
        mem[16'h0234] = 8'h5C;
        mem[16'hBEEF] = 8'h03;
        do_op(SMIE_OP_COPY_FILE, 7'h00, 1'b0, 1'b1, 1'b0, 2'h0, 6'h00,
              16'h0234, 8'h5C, exp_c);
        do_op(SMIE_OP_SHIFT_RIGHT, 7'h01, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00,
              16'hBEEF, 8'h01, 1'b1);
        chk_ptrs();
    endtask : test_alias

    // a start with no operation, or while busy, is ignored
    task test_refuse();
        mem[16'h0026] = 8'h3C;
        issue(SMIE_OP_NONE, 7'h26, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00);
        @(negedge clk);
        check({busy, mem_rd}, 2'h0);
        op = SMIE_OP_COPY_FILE;
        @(negedge clk);
        op = SMIE_OP_SHIFT_RIGHT;
        faddr = 7'h31;
        dest_sel = 1'b0;
        check(mem_addr, 16'h0026);
        @(negedge clk);
        start = 1'b0;
        check(mem_wr, 1'b1);
        check(mem_wdata, 8'h3C);
        @(negedge clk);
        check({busy, done, mem_rd}, 3'h2);
        check(acc, exp_acc);
        check(carry, exp_c);
        check(zero, 1'b0);
        check(mem[16'h0026], 8'h3C);
    endtask : test_refuse

    // clock enable low freezes an instruction in flight
    task test_ce();
        mem[16'h0040] = 8'h03;
        issue(SMIE_OP_SHIFT_RIGHT, 7'h40, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00);
        @(negedge clk);
        start = 1'b0;
        ce = 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            check({busy, mem_rd, mem_wr}, 3'h6);
            check(acc, exp_acc);
        end
        ce = 1'b1;
        @(negedge clk);
        check({mem_rd, mem_wr}, 2'h0);
        @(negedge clk);
        exp_acc = 8'h01;
        exp_c = 1'b1;
        check(acc, exp_acc);
        check(carry, exp_c);
        check({busy, done, zero}, 3'h2);
    endtask : test_ce

    // reset in the middle of an instruction abandons it
    task test_midreset();
        issue(SMIE_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, 1'b0, 2'h2, 6'h00);
        @(negedge clk);
        start = 1'b0;
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        exp_acc = `SMIE_ACC_RST;
        exp_c = `SMIE_FLAG_RST;
        exp_p[0] = `SMIE_PTR_RST;
        exp_p[1] = `SMIE_PTR_RST;
        test_reset();
        @(negedge clk);
        check({busy, done, mem_rd, mem_wr}, 4'h0);
        chk_ptrs();
        do_op(SMIE_OP_COPY_FILE, 7'h31, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00,
              16'h0031, 8'hA5, exp_c);
    endtask : test_midreset

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        op = SMIE_OP_NONE;
        faddr = 7'h00;
        dest_sel = 1'b0;
        ptr_sel = 1'b0;
        rel = 1'b0;
        upd_mode = 2'h0;
        offset = 6'h00;
        ptr_ld = 1'b0;
        ptr_ld_val = 16'h0000;
        err_count = 0;
        comparisons = 0;
        exp_acc = 8'h00;
        exp_c = 1'b0;
        exp_p[0] = 16'h0000;
        exp_p[1] = 16'h0000;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hC3;
        repeat (20) @(negedge clk);
        test_reset();
        rst_n = 1'b1;
        test_shift();
        test_copy();
        test_modes();
        test_rel();
        test_alias();
        test_refuse();
        test_ce();
        test_midreset();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
